// [rtl/ddt_timer.v]
// Summary of operation
// R1 - counting happens only while the module enable input is high
// R2 - three-bit mode field picks one of seven counter layouts; value 7 picks none
// R3 - software must not use mode 7; here it simply counts nothing
// R4 - no interrupt output; underflow shows in polled full flags and, in modes 1 to 3, in the timer 1 baud tick
// R5 - both timers may count 12 MHz RC divided by 1, 8, 32, 128, 512
// R6 - both timers may count 4.4 kHz from both edges of 2.2 kHz
// R7 - timer 0 may count timer 1 underflows or 90 kHz divided by 8
// R8 - timer 1 may count rising edges on general-purpose pin two
// R9 - with crystal enable: crystal/6 for both, crystal/512 for timer 0
// R10 - software byte loads are taken on the system clock, not count ticks
// R11 - single-run timer counts down to zero, underflows on next tick
// R12 - single-run underflow clears the run bit and sets the full flag
// R13 - reloading timer loads from its reload register on underflow
// R14 - reload full flag sticks until cleared; run bit starts and stops
// R15 - mode 0: timer 0 sixteen-bit reloading from timer 1 bytes
// R16 - mode 1: timer 0 sixteen-bit single, timer 1 eight-bit reload
// R17 - mode 2: two eight-bit reloading timers, high byte is reload
// R18 - mode 3: timer 0 bytes two single timers, timer 1 eight-bit reload
// R19 - mode 4: timer 1 sixteen-bit reloading from timer 0 bytes
// R20 - mode 5: timer 0 eight-bit reload, timer 1 sixteen-bit single
// R21 - mode 6: two independent sixteen-bit single-run timers
// R22 - modes 1 to 3: timer 1 underflow drives the baud tick output
// R23 - select and mode encodings are fixed in the constants header
// R24 - all clock sources are synchronised into the system clock domain
`timescale 1ns/10ps
`include "ddt_consts.vh"
module ddt_timer (
  input wire clk,
  input wire rst,
  input wire timer_module_enable,
  input wire [2:0] timer_mode_select,
  input wire [3:0] timer0_count_clock_select,
  input wire [3:0] timer1_count_clock_select,
  input wire timer_crystal_clock_enable,
  input wire osc_rc12_in,
  input wire osc_lp2k2_in,
  input wire osc_rc90_in,
  input wire osc_xtal_in,
  input wire general_purpose_pin_two,
  input wire [7:0] wr_data,
  input wire timer0_low_byte_wr,
  input wire timer0_high_byte_wr,
  input wire timer1_low_byte_wr,
  input wire timer1_high_byte_wr,
  input wire timer0_run_wr,
  input wire timer0_run_wdata,
  input wire timer1_run_wr,
  input wire timer1_run_wdata,
  input wire timer0_full_clr,
  input wire timer1_full_clr,
  output reg [7:0] timer0_low_byte_q,
  output reg [7:0] timer0_high_byte_q,
  output reg [7:0] timer1_low_byte_q,
  output reg [7:0] timer1_high_byte_q,
  output reg timer0_run_bit_q,
  output reg timer1_run_bit_q,
  output reg timer0_full_flag_q,
  output reg timer1_full_flag_q,
  output reg baud_tick_q
);
  wire [`DDT_SRC_N-1:0] src_raw;
  wire [`DDT_SRC_N-1:0] src_level;
  wire [`DDT_SRC_N-1:0] src_rise;
  wire [`DDT_SRC_N-1:0] src_fall;
  wire [3:0] rc12_div_tick;
  wire rc90_div8_tick;
  wire xtal_div6_tick;
  wire xtal_div512_tick;
  wire lp4k4_tick;
  wire xtal_div6_gated;
  wire xtal_div512_gated;
  wire [`DDT_SRC_W-1:0] t0_src;
  wire [`DDT_SRC_W-1:0] t1_src;
  wire tick0;
  wire tick1;
  reg uf1;
  reg [7:0] c0l_d;
  reg [7:0] c0h_d;
  reg [7:0] c1l_d;
  reg [7:0] c1h_d;
  reg run0_d;
  reg run1_d;
  reg full0_set;
  reg full1_set;
  reg [15:0] cnt16;

  // pick one count tick from a source vector by select code
  function pick_tick;
    input [3:0] sel;
    input [15:0] vec;
    begin
      pick_tick = vec[sel];
    end
  endfunction

  assign src_raw[`DDT_SRC_RC12] = osc_rc12_in;
  assign src_raw[`DDT_SRC_LP2K2] = osc_lp2k2_in;
  assign src_raw[`DDT_SRC_RC90] = osc_rc90_in;
  assign src_raw[`DDT_SRC_XTAL] = osc_xtal_in;
  assign src_raw[`DDT_SRC_PIN2] = general_purpose_pin_two;

  // a level must last two clk cycles, so a source faster than a quarter of clk aliases; 12 MHz needs clk of at least 48 MHz
  genvar gi;
  generate
    for (gi = 0; gi < `DDT_SRC_N; gi = gi + 1) begin : g_sync
      ddt_sync u_sync ( // R24
        .clk(clk),
        .rst(rst),
        .async_in(src_raw[gi]),
        .level_q(src_level[gi]),
        .rise_q(src_rise[gi]),
        .fall_q(src_fall[gi])
      );
    end
  endgenerate

  ddt_div #(.RATIO(`DDT_DIV_8)) u_rc12_div8 ( // R5
    .clk(clk),
    .rst(rst),
    .tick_in(src_rise[`DDT_SRC_RC12]),
    .tick_q(rc12_div_tick[0])
  );

  ddt_div #(.RATIO(`DDT_DIV_32)) u_rc12_div32 ( // R5
    .clk(clk),
    .rst(rst),
    .tick_in(src_rise[`DDT_SRC_RC12]),
    .tick_q(rc12_div_tick[1])
  );

  ddt_div #(.RATIO(`DDT_DIV_128)) u_rc12_div128 ( // R5
    .clk(clk),
    .rst(rst),
    .tick_in(src_rise[`DDT_SRC_RC12]),
    .tick_q(rc12_div_tick[2])
  );

  ddt_div #(.RATIO(`DDT_DIV_512)) u_rc12_div512 ( // R5
    .clk(clk),
    .rst(rst),
    .tick_in(src_rise[`DDT_SRC_RC12]),
    .tick_q(rc12_div_tick[3])
  );

  ddt_div #(.RATIO(`DDT_DIV_8)) u_rc90_div8 ( // R7
    .clk(clk),
    .rst(rst),
    .tick_in(src_rise[`DDT_SRC_RC90]),
    .tick_q(rc90_div8_tick)
  );

  ddt_div #(.RATIO(`DDT_DIV_6)) u_xtal_div6 ( // R9
    .clk(clk),
    .rst(rst),
    .tick_in(src_rise[`DDT_SRC_XTAL]),
    .tick_q(xtal_div6_tick)
  );

  ddt_div #(.RATIO(`DDT_DIV_512)) u_xtal_div512 ( // R9
    .clk(clk),
    .rst(rst),
    .tick_in(src_rise[`DDT_SRC_XTAL]),
    .tick_q(xtal_div512_tick)
  );

  // both edges of the low-power clock double it
  assign lp4k4_tick = src_rise[`DDT_SRC_LP2K2] | src_fall[`DDT_SRC_LP2K2]; // R6
  assign xtal_div6_gated = xtal_div6_tick & timer_crystal_clock_enable; // R9
  assign xtal_div512_gated = xtal_div512_tick & timer_crystal_clock_enable; // R9

  // R23
  assign t0_src = {6'h00, xtal_div512_gated, xtal_div6_gated, rc90_div8_tick, uf1, lp4k4_tick,
                   rc12_div_tick, src_rise[`DDT_SRC_RC12]}; // R7
  assign t1_src = {6'h00, 1'b0, xtal_div6_gated, 1'b0, src_rise[`DDT_SRC_PIN2], lp4k4_tick,
                   rc12_div_tick, src_rise[`DDT_SRC_RC12]}; // R8

  assign tick0 = pick_tick(timer0_count_clock_select, t0_src);
  assign tick1 = pick_tick(timer1_count_clock_select, t1_src);

  // timer 1 underflow, kept apart from the main block so the chain has no loop
  always @* begin
    uf1 = 1'b0;
    if (timer_module_enable && tick1) begin
      case (timer_mode_select)
        `DDT_MODE_16S_8R: begin
          uf1 = timer1_run_bit_q && (timer1_low_byte_q == 8'h00);
        end
        `DDT_MODE_8R_8R: begin
          uf1 = timer1_run_bit_q && (timer1_low_byte_q == 8'h00);
        end
        `DDT_MODE_8S_8S_8R: begin
          // run and full bits belong to the second byte timer, so this one runs free
          uf1 = (timer1_low_byte_q == 8'h00);
        end
        `DDT_MODE_16R_T1: begin
          uf1 = timer1_run_bit_q && ({timer1_high_byte_q, timer1_low_byte_q} == 16'h0000);
        end
        `DDT_MODE_8R_16S: begin
          uf1 = timer1_run_bit_q && ({timer1_high_byte_q, timer1_low_byte_q} == 16'h0000);
        end
        `DDT_MODE_16S_16S: begin
          uf1 = timer1_run_bit_q && ({timer1_high_byte_q, timer1_low_byte_q} == 16'h0000);
        end
        default: begin
          uf1 = 1'b0;
        end
      endcase
    end
  end

  always @* begin
    c0l_d = timer0_low_byte_q;
    c0h_d = timer0_high_byte_q;
    c1l_d = timer1_low_byte_q;
    c1h_d = timer1_high_byte_q;
    run0_d = timer0_run_bit_q;
    run1_d = timer1_run_bit_q;
    full0_set = 1'b0;
    full1_set = 1'b0;
    cnt16 = 16'h0000;
    if (timer_module_enable) begin // R1
      case (timer_mode_select) // R2
        `DDT_MODE_16R_T0: begin
          if (timer0_run_bit_q && tick0) begin // R15
            cnt16 = {timer0_high_byte_q, timer0_low_byte_q};
            if (cnt16 == 16'h0000) begin
              {c0h_d, c0l_d} = {timer1_high_byte_q, timer1_low_byte_q}; // R13
              full0_set = 1'b1; // R14
            end else begin
              {c0h_d, c0l_d} = cnt16 - 16'h0001;
            end
          end
        end
        `DDT_MODE_16S_8R: begin
          if (timer0_run_bit_q && tick0) begin // R16
            cnt16 = {timer0_high_byte_q, timer0_low_byte_q};
            if (cnt16 == 16'h0000) begin // R11
              run0_d = 1'b0; // R12
              full0_set = 1'b1;
            end else begin
              {c0h_d, c0l_d} = cnt16 - 16'h0001;
            end
          end
          if (uf1) begin
            c1l_d = timer1_high_byte_q; // R13
            full1_set = 1'b1; // R14
          end else if (timer1_run_bit_q && tick1) begin
            c1l_d = timer1_low_byte_q - 8'h01;
          end
        end
        `DDT_MODE_8R_8R: begin
          if (timer0_run_bit_q && tick0) begin // R17
            if (timer0_low_byte_q == 8'h00) begin
              c0l_d = timer0_high_byte_q; // R13
              full0_set = 1'b1; // R14
            end else begin
              c0l_d = timer0_low_byte_q - 8'h01;
            end
          end
          if (uf1) begin
            c1l_d = timer1_high_byte_q;
            full1_set = 1'b1;
          end else if (timer1_run_bit_q && tick1) begin
            c1l_d = timer1_low_byte_q - 8'h01;
          end
        end
        `DDT_MODE_8S_8S_8R: begin
          if (timer0_run_bit_q && tick0) begin // R18
            if (timer0_low_byte_q == 8'h00) begin // R11
              run0_d = 1'b0; // R12
              full0_set = 1'b1;
            end else begin
              c0l_d = timer0_low_byte_q - 8'h01;
            end
          end
          // second byte timer shares the timer 1 count clock
          if (timer1_run_bit_q && tick1) begin // R18
            if (timer0_high_byte_q == 8'h00) begin
              run1_d = 1'b0; // R12
              full1_set = 1'b1;
            end else begin
              c0h_d = timer0_high_byte_q - 8'h01;
            end
          end
          if (uf1) begin
            c1l_d = timer1_high_byte_q; // R13
          end else if (tick1) begin
            c1l_d = timer1_low_byte_q - 8'h01;
          end
        end
        `DDT_MODE_16R_T1: begin
          if (uf1) begin // R19
            {c1h_d, c1l_d} = {timer0_high_byte_q, timer0_low_byte_q}; // R13
            full1_set = 1'b1; // R14
          end else if (timer1_run_bit_q && tick1) begin
            cnt16 = {timer1_high_byte_q, timer1_low_byte_q};
            {c1h_d, c1l_d} = cnt16 - 16'h0001;
          end
        end
        `DDT_MODE_8R_16S: begin
          if (timer0_run_bit_q && tick0) begin // R20
            if (timer0_low_byte_q == 8'h00) begin
              c0l_d = timer0_high_byte_q; // R13
              full0_set = 1'b1;
            end else begin
              c0l_d = timer0_low_byte_q - 8'h01;
            end
          end
          if (uf1) begin // R20
            run1_d = 1'b0; // R12
            full1_set = 1'b1;
          end else if (timer1_run_bit_q && tick1) begin
            cnt16 = {timer1_high_byte_q, timer1_low_byte_q};
            {c1h_d, c1l_d} = cnt16 - 16'h0001; // R11
          end
        end
        `DDT_MODE_16S_16S: begin
          if (timer0_run_bit_q && tick0) begin // R21
            cnt16 = {timer0_high_byte_q, timer0_low_byte_q};
            if (cnt16 == 16'h0000) begin // R11
              run0_d = 1'b0; // R12
              full0_set = 1'b1;
            end else begin
              {c0h_d, c0l_d} = cnt16 - 16'h0001;
            end
          end
          if (uf1) begin // R21
            run1_d = 1'b0; // R12
            full1_set = 1'b1;
          end else if (timer1_run_bit_q && tick1) begin
            {c1h_d, c1l_d} = {timer1_high_byte_q, timer1_low_byte_q} - 16'h0001;
          end
        end
        default: begin
          // calibration layout is not offered; registers simply hold
          c0l_d = timer0_low_byte_q; // R3
        end
      endcase
    end
    // software loads win over a count in the same cycle
    if (timer0_low_byte_wr) begin // R10
      c0l_d = wr_data;
    end
    if (timer0_high_byte_wr) begin // R10
      c0h_d = wr_data;
    end
    if (timer1_low_byte_wr) begin // R10
      c1l_d = wr_data;
    end
    if (timer1_high_byte_wr) begin // R10
      c1h_d = wr_data;
    end
    // a run write of one in the underflow cycle restarts rather than stops
    if (timer0_run_wr) begin // R14
      run0_d = timer0_run_wdata;
    end
    if (timer1_run_wr) begin // R14
      run1_d = timer1_run_wdata;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      timer0_low_byte_q <= `DDT_BYTE_RST;
      timer0_high_byte_q <= `DDT_BYTE_RST;
      timer1_low_byte_q <= `DDT_BYTE_RST;
      timer1_high_byte_q <= `DDT_BYTE_RST;
      timer0_run_bit_q <= `DDT_BIT_RST;
      timer1_run_bit_q <= `DDT_BIT_RST;
      timer0_full_flag_q <= `DDT_BIT_RST;
      timer1_full_flag_q <= `DDT_BIT_RST;
      baud_tick_q <= `DDT_BIT_RST;
    end else begin
      timer0_low_byte_q <= c0l_d;
      timer0_high_byte_q <= c0h_d;
      timer1_low_byte_q <= c1l_d;
      timer1_high_byte_q <= c1h_d;
      timer0_run_bit_q <= run0_d;
      timer1_run_bit_q <= run1_d;
      // set beats clear; flags and the modes 1 to 3 baud tick are the only underflow indications
      timer0_full_flag_q <= full0_set | (timer0_full_flag_q & ~timer0_full_clr); // R4
      timer1_full_flag_q <= full1_set | (timer1_full_flag_q & ~timer1_full_clr); // R14
      baud_tick_q <= uf1 && ((timer_mode_select == `DDT_MODE_16S_8R) ||
                             (timer_mode_select == `DDT_MODE_8R_8R) ||
                             (timer_mode_select == `DDT_MODE_8S_8S_8R)); // R22
    end
  end
endmodule // ddt_timer

// [rtl/ddt_consts.vh]
`ifndef DDT_CONSTS_VH
`define DDT_CONSTS_VH

// timer mode field values
`define DDT_MODE_W 3
`define DDT_MODE_16R_T0 3'h0
`define DDT_MODE_16S_8R 3'h1
`define DDT_MODE_8R_8R 3'h2
`define DDT_MODE_8S_8S_8R 3'h3
`define DDT_MODE_16R_T1 3'h4
`define DDT_MODE_8R_16S 3'h5
`define DDT_MODE_16S_16S 3'h6
`define DDT_MODE_CALIB 3'h7

// count clock select codes
`define DDT_SEL_W 4
`define DDT_SEL_RC12_DIV1 4'h0
`define DDT_SEL_RC12_DIV8 4'h1
`define DDT_SEL_RC12_DIV32 4'h2
`define DDT_SEL_RC12_DIV128 4'h3
`define DDT_SEL_RC12_DIV512 4'h4
`define DDT_SEL_LP_4K4 4'h5
`define DDT_SEL_CHAIN_OR_PIN 4'h6
`define DDT_SEL_RC90_DIV8 4'h7
`define DDT_SEL_XTAL_DIV6 4'h8
`define DDT_SEL_XTAL_DIV512 4'h9

// source vector bit positions
`define DDT_SRC_W 16
`define DDT_SRC_N 5
`define DDT_SRC_RC12 0
`define DDT_SRC_LP2K2 1
`define DDT_SRC_RC90 2
`define DDT_SRC_XTAL 3
`define DDT_SRC_PIN2 4

// divider ratios
`define DDT_DIV_8 10'h008
`define DDT_DIV_32 10'h020
`define DDT_DIV_128 10'h080
`define DDT_DIV_512 10'h200
`define DDT_DIV_6 10'h006

// reset values
`define DDT_BYTE_RST 8'h00
`define DDT_BIT_RST 1'b0

`endif

// [rtl/ddt_sync.v]
`timescale 1ns/10ps
module ddt_sync (
  input wire clk,
  input wire rst,
  input wire async_in,
  output reg level_q,
  output reg rise_q,
  output reg fall_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk) begin
    if (rst) begin
      // track the input through reset so an idle-high pin gives no false edge
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= s3_q;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      // change accepted only when stages two and three agree
      if ((s2_q == s3_q) && (s3_q != level_q)) begin
        level_q <= s3_q;
        rise_q <= s3_q;
        fall_q <= ~s3_q;
      end
    end
  end
endmodule // ddt_sync

// [rtl/ddt_div.v]
`timescale 1ns/10ps
module ddt_div #(
  parameter [9:0] RATIO = 10'h008
) (
  input wire clk,
  input wire rst,
  input wire tick_in,
  output reg tick_q
);
  reg [8:0] cnt_q;

  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 9'h000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (tick_in) begin
        if ({1'b0, cnt_q} == (RATIO - 10'h001)) begin
          cnt_q <= 9'h000;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 9'h001;
        end
      end
    end
  end
endmodule // ddt_div

// [bench/ddt_timer_monitor.sv]
`timescale 1ns/10ps
module ddt_timer_monitor (
  input wire clk,
  input wire rst,
  input wire timer_module_enable,
  input wire [2:0] timer_mode_select,
  input wire [7:0] wr_data,
  input wire timer0_low_byte_wr,
  input wire timer0_high_byte_wr,
  input wire timer0_run_wr,
  input wire timer0_run_wdata,
  input wire timer0_full_clr,
  input wire [7:0] timer0_low_byte_q,
  input wire [7:0] timer0_high_byte_q,
  input wire timer0_run_bit_q,
  input wire timer0_full_flag_q,
  input wire timer1_full_flag_q,
  input wire baud_tick_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // a load must win over a count landing in the same cycle
  byte_load_a: assert property (timer0_low_byte_wr |=> timer0_low_byte_q == $past(wr_data))
    else $error("byte load lost");
  run_load_a: assert property (timer0_run_wr |=> timer0_run_bit_q == $past(timer0_run_wdata))
    else $error("run write lost");
  run_stop_a: assert property ($fell(timer0_run_bit_q) && !$past(timer0_run_wr) |-> timer0_full_flag_q)
    else $error("run cleared without full");
  full_hold_a: assert property (timer0_full_flag_q && !timer0_full_clr |=> timer0_full_flag_q)
    else $error("full flag dropped");
  idle_freeze_a: assert property (!timer_module_enable && !timer0_low_byte_wr && !timer0_high_byte_wr
    |=> $stable({timer0_high_byte_q, timer0_low_byte_q}) && !$rose(timer0_full_flag_q))
    else $error("count while disabled");
  single_end_a: assert property ($rose(timer0_full_flag_q) && timer_mode_select == 3'h6
    |-> {timer0_high_byte_q, timer0_low_byte_q} == 16'h0000 && !timer0_run_bit_q)
    else $error("single run end wrong");
  unused_full_a: assert property (timer_mode_select == 3'h0 |=> !$rose(timer1_full_flag_q))
    else $error("unused full set");
  baud_mode_a: assert property (baud_tick_q |-> $past(timer_mode_select) inside {3'h1, 3'h2, 3'h3})
    else $error("baud in wrong mode");
  baud_pulse_a: assert property (baud_tick_q |=> !baud_tick_q)
    else $error("baud pulse too long");
endmodule // ddt_timer_monitor
bind ddt_timer ddt_timer_monitor ddt_timer_monitor_i (.clk, .rst, .timer_module_enable, .timer_mode_select,
  .wr_data, .timer0_low_byte_wr, .timer0_high_byte_wr, .timer0_run_wr, .timer0_run_wdata, .timer0_full_clr,
  .timer0_low_byte_q, .timer0_high_byte_q, .timer0_run_bit_q, .timer0_full_flag_q, .timer1_full_flag_q,
  .baud_tick_q);

// [bench/ddt_timer_tb.sv]
`timescale 1ns/10ps
`include "ddt_consts.vh"
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end
module ddt_timer_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg en = 1'b0;
  reg xen = 1'b0;
  reg [2:0] mode = 3'h0;
  reg [3:0] sel0 = 4'h0;
  reg [3:0] sel1 = 4'h0;
  reg [4:0] osc = 5'h00;
  reg [7:0] wd = 8'h00;
  reg [3:0] bwr = 4'h0;
  reg [1:0] rwr = 2'h0;
  reg [1:0] rwd = 2'h0;
  reg [1:0] fclr = 2'h0;
  wire [7:0] b0l, b0h, b1l, b1h;
  wire r0, r1, f0, f1, baud;
  wire [31:0] bytes = {b1h, b1l, b0h, b0l};
  wire [3:0] flags = {f1, f0, r1, r0};
  integer n_mismatch = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer nbaud = 0;
  always #25 clk = ~clk;
  // osc bits: 0 rc12, 1 low power, 2 rc90, 3 crystal, 4 pin two
  ddt_timer ddt_timer_i (.clk(clk), .rst(rst), .timer_module_enable(en), .timer_mode_select(mode),
    .timer0_count_clock_select(sel0), .timer1_count_clock_select(sel1), .timer_crystal_clock_enable(xen),
    .osc_rc12_in(osc[0]), .osc_lp2k2_in(osc[1]), .osc_rc90_in(osc[2]), .osc_xtal_in(osc[3]),
    .general_purpose_pin_two(osc[4]), .wr_data(wd), .timer0_low_byte_wr(bwr[0]), .timer0_high_byte_wr(bwr[1]),
    .timer1_low_byte_wr(bwr[2]), .timer1_high_byte_wr(bwr[3]), .timer0_run_wr(rwr[0]),
    .timer0_run_wdata(rwd[0]), .timer1_run_wr(rwr[1]), .timer1_run_wdata(rwd[1]),
    .timer0_full_clr(fclr[0]), .timer1_full_clr(fclr[1]), .timer0_low_byte_q(b0l), .timer0_high_byte_q(b0h),
    .timer1_low_byte_q(b1l), .timer1_high_byte_q(b1h), .timer0_run_bit_q(r0), .timer1_run_bit_q(r1),
    .timer0_full_flag_q(f0), .timer1_full_flag_q(f1), .baud_tick_q(baud));
  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // baud is a one-cycle pulse, settled by the falling edge
  always @(negedge clk) begin
    cyc = cyc + 1;
    if (rst) nbaud = 0;
    else if (baud === 1'b1) nbaud = nbaud + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim;
    end
  end
  task step(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wb(input integer i, input [7:0] v);
    wd = v;
    bwr[i] = 1'b1;
    step(1);
    bwr = 4'h0;
    step(1);
  endtask
  task wr(input integer i, input v);
    rwd[i] = v;
    rwr[i] = 1'b1;
    step(1);
    rwr = 2'h0;
    step(1);
  endtask
  // slow square waves: rc12 at full rate would alias against clk
  task pulse(input integer s, input integer n);
    repeat (n) begin
      osc[s] = 1'b1;
      step(6);
      osc[s] = 1'b0;
      step(6);
    end
  endtask
  task setup(input [2:0] m, input [31:0] b, input [1:0] r);
    rst = 1'b1;
    mode = m;
    en = 1'b1;
    sel0 = 4'h0;
    sel1 = 4'h0;
    xen = 1'b0;
    step(20);
    rst = 1'b0;
    step(1);
    wb(0, b[7:0]);
    wb(1, b[15:8]);
    wb(2, b[23:16]);
    wb(3, b[31:24]);
    wr(0, r[0]);
    wr(1, r[1]);
  endtask
  task st(input t, input [3:0] c, input integer s, input integer n, input x, input [7:0] e);
    setup(3'h6, 32'h00050005, 2'h3);
    sel0 = c;
    sel1 = c;
    xen = x;
    pulse(s, n - 1);
    `CK("sel pre", 8'h05, (t ? b1l : b0l));
    pulse(s, 1);
    `CK("sel post", e, (t ? b1l : b0l));
  endtask
  initial begin
    step(20);
    `CK("reset", 37'h0, {bytes, flags, baud});
    st(0, `DDT_SEL_RC12_DIV1, 0, 1, 0, 8'h04);
    st(0, `DDT_SEL_RC12_DIV8, 0, 8, 0, 8'h04);
    st(0, `DDT_SEL_RC12_DIV32, 0, 32, 0, 8'h04);
    st(0, `DDT_SEL_RC12_DIV128, 0, 128, 0, 8'h04);
    st(0, `DDT_SEL_RC12_DIV512, 0, 512, 0, 8'h04);
    st(0, `DDT_SEL_LP_4K4, 1, 1, 0, 8'h03);
    st(0, `DDT_SEL_RC90_DIV8, 2, 8, 0, 8'h04);
    st(0, `DDT_SEL_XTAL_DIV6, 3, 6, 1, 8'h04);
    st(0, `DDT_SEL_XTAL_DIV6, 3, 6, 0, 8'h05);
    st(0, `DDT_SEL_XTAL_DIV512, 3, 512, 1, 8'h04);
    st(1, `DDT_SEL_RC12_DIV8, 0, 8, 0, 8'h04);
    st(1, `DDT_SEL_LP_4K4, 1, 1, 0, 8'h03);
    st(1, `DDT_SEL_CHAIN_OR_PIN, 4, 1, 0, 8'h04);
    st(1, `DDT_SEL_XTAL_DIV6, 3, 6, 1, 8'h04);
    st(1, `DDT_SEL_RC90_DIV8, 2, 8, 0, 8'h05);
    setup(3'h6, 32'h01000001, 2'h3);
    pulse(0, 1);
    `CK("m6", 32'h00ff0000, bytes);
    en = 1'b0;
    pulse(0, 1);
    `CK("frozen", 32'h00ff0000, bytes);
    en = 1'b1;
    pulse(0, 2);
    `CK("m6 end", 32'h00fd0000, bytes);
    `CK("m6 flags", 4'h6, flags);
    fclr = 2'h1;
    step(1);
    fclr = 2'h0;
    `CK("m6 clr", 4'h2, flags);
    setup(3'h2, 32'h07000301, 2'h3);
    pulse(0, 2);
    `CK("m2", 32'h07060303, bytes);
    `CK("m2 flags", 4'hf, flags);
    `CK("m2 baud", 1, nbaud);
    wr(0, 1'b0);
    pulse(0, 1);
    `CK("m2 stop", 32'h07050303, bytes);
    `CK("m2 sticky", 4'he, flags);
    setup(3'h0, 32'h12340001, 2'h3);
    pulse(0, 2);
    `CK("m0", 32'h12341234, bytes);
    `CK("m0 flags", 4'h7, flags);
    setup(3'h4, 32'h0001abcd, 2'h3);
    pulse(0, 2);
    `CK("m4", 32'habcdabcd, bytes);
    `CK("m4 flags", 4'hb, flags);
    setup(3'h5, 32'h00000900, 2'h3);
    pulse(0, 1);
    `CK("m5", 32'h00000909, bytes);
    `CK("m5 flags", 4'hd, flags);
    `CK("m5 baud", 0, nbaud);
    setup(3'h1, 32'h05000100, 2'h3);
    pulse(0, 1);
    `CK("m1", 32'h050500ff, bytes);
    `CK("m1 baud", 1, nbaud);
    setup(3'h3, 32'h04000201, 2'h3);
    pulse(0, 3);
    `CK("m3", 32'h04020000, bytes);
    `CK("m3 flags", 4'hc, flags);
    `CK("m3 baud", 1, nbaud);
    setup(3'h7, 32'h01010101, 2'h3);
    pulse(0, 1);
    `CK("m7", 32'h01010101, bytes);
    setup(3'h2, 32'h01000505, 2'h3);
    sel0 = `DDT_SEL_CHAIN_OR_PIN;
    pulse(0, 3);
    `CK("chain", 32'h01010503, bytes);
    end_sim;
  end
endmodule // ddt_timer_tb
